// [src/aprc_defines.vh]
// Register map, field positions, reset values and codes for the pin routing block
`ifndef APRC_DEFINES_VH
`define APRC_DEFINES_VH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define APRC_IDX_PWR_PIN 8'h14
`define APRC_IDX_BIAS 8'h15
`define APRC_IDX_PORT 8'h18
`define APRC_IDX_LANE 8'h19
`define APRC_IDX_W 8
`define APRC_ADDR_LSB 2

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define APRC_RST_PWR_PIN 8'h00
`define APRC_RST_BIAS 8'h00
`define APRC_RST_PORT 8'h40
`define APRC_RST_LANE 8'h00
`define APRC_MASK_BIAS 8'hC0
`define APRC_MASK_LANE 8'hF8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define APRC_F_OVRD 7
`define APRC_F_SHARED 6
`define APRC_F_ADC_PD 5:4
`define APRC_F_DAC_PD 3:2
`define APRC_F_LIM 1
`define APRC_F_ANA 0
`define APRC_F_BIAS 7:6
`define APRC_F_PDIS 7
`define APRC_F_SDIS 6
`define APRC_F_GANG 5
`define APRC_F_DAISY 4:3
`define APRC_F_DIN_SEL 2:0
`define APRC_F_OUT_SPLIT 7:6
`define APRC_F_IN_SPLIT 5:4
`define APRC_F_DIR 3

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define APRC_PIN_NONE 2'h0
`define APRC_PIN_G1 2'h1
`define APRC_PIN_G2 2'h2
`define APRC_PIN_IN 2'h3
`define APRC_SRC_NONE 3'h0
`define APRC_SRC_G1 3'h1
`define APRC_SRC_G2 3'h2
`define APRC_SRC_IN 3'h3
`define APRC_SRC_DIN 3'h5
`define APRC_DAISY_OFF 2'h0
`define APRC_DAISY_PRI 2'h1
`define APRC_DAISY_SEC 2'h2
`define APRC_SPLIT_EACH 2'h0
`define APRC_SPLIT_PRI 2'h1
`define APRC_SPLIT_SEC 2'h2
`define APRC_MIC_DIN 2'h3

// ----------------------------------------------------------------
// AHB-Lite encodings
// ----------------------------------------------------------------
`define APRC_HTRANS_NONSEQ 2'h2
`define APRC_HSIZE_WORD 3'h2

`endif

// [src/aprc_pin_routing.v]
// Pin routing and audio serial port organisation with an AHB-Lite register slave
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "aprc_defines.vh"

module aprc_pin_routing (
    input wire CORE_CLK_I, // Core clock, 125 MHz
    input wire RST_N_I, // Asynchronous active-low reset
    input wire HSEL_I, // AHB slave select
    input wire [31:0] HADDR_I, // AHB byte address
    input wire [1:0] HTRANS_I, // AHB transfer type
    input wire HWRITE_I, // AHB write flag
    input wire [2:0] HSIZE_I, // AHB transfer size
    input wire [31:0] HWDATA_I, // AHB write data
    input wire HREADY_I, // AHB bus ready
    output wire [31:0] HRDATA_O, // AHB read data
    output wire HREADYOUT_O, // AHB slave ready
    output wire HRESP_O, // AHB response, always OKAY
    input wire GENERAL_PIN_ONE_I, // Level on general pin one
    input wire GENERAL_PIN_TWO_I, // Level on general pin two
    input wire INPUT_ONLY_PIN_I, // Level on the input-only pin
    input wire ADC_REGISTER_POWER_CONTROL_I, // High keeps ADC powered
    input wire DAC_REGISTER_POWER_CONTROL_I, // High keeps DAC powered
    input wire [1:0] MIC_LANE_SELECT_I, // Mic data lane pin select
    output reg [1:0] MIC_LANE_ROUTE_O, // Effective mic lane route
    output reg MIC_LANE_FROM_DIN_O, // Mic lane taken from data-in pin
    output reg SHARED_DATA_PIN_O, // Output pin also carries data-in
    output reg ADC_POWERDOWN_O, // ADC powered down
    output reg DAC_POWERDOWN_O, // DAC powered down
    output reg POWER_LIMITER_ON_PIN_O, // Limiter assigned to pin one
    output reg GENERAL_ANALOG_ON_PIN_O, // Analog function on pin one
    output reg MICROPHONE_BIAS_EN_O, // Bias enabled by selected pin
    output reg PRIMARY_PORT_EN_O, // Primary serial port enabled
    output reg SECONDARY_PORT_EN_O, // Secondary serial port enabled
    output reg PORT_CONFIG_GANG_O, // Secondary follows primary config
    output reg DAISY_PRIMARY_O, // Primary port daisy chained
    output reg DAISY_SECONDARY_O, // Secondary port daisy chained
    output reg DAISY_INPUT_O, // Selected daisy chain input level
    output reg DAISY_ON_INPUT_PATH_O, // Chain runs on data-in path
    output reg [1:0] PRIMARY_OUT_LANES_O, // Output lanes for primary
    output reg [1:0] SECONDARY_OUT_LANES_O, // Output lanes for secondary
    output reg [1:0] PRIMARY_IN_LANES_O, // Input lanes for primary
    output reg [1:0] SECONDARY_IN_LANES_O // Input lanes for secondary
);

    // ----------------------------------------------------------------
    // Reset synchroniser
    // ----------------------------------------------------------------
    reg rst_meta_ff; // First stage, read by second only
    reg rst_sync_ff; // Synchronised reset, active high when released
    wire rst_n = rst_sync_ff; // Reset used by the rest of the block

    // Asynchronous assert, release through two flops
    always @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    reg [7:0] pwr_pin_ff; // Power and pin function select
    reg [7:0] bias_ff; // Bias pin select, low bits reserved
    reg [7:0] port_ff; // Port enable and daisy setup
    reg [7:0] lane_ff; // Lane split and daisy direction

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    reg wr_pend_ff; // Write data phase pending
    reg [`APRC_IDX_W-1:0] wr_idx_ff; // Index latched in address phase
    reg [31:0] rdata_ff; // Read data held for the data phase
    wire [`APRC_IDX_W-1:0] a_idx; // Word index of the address
    wire a_valid; // Valid single-word transfer

    assign a_idx = HADDR_I[`APRC_IDX_W+`APRC_ADDR_LSB-1:`APRC_ADDR_LSB];
    assign a_valid = HSEL_I && HREADY_I && (HTRANS_I == `APRC_HTRANS_NONSEQ)
                     && (HSIZE_I == `APRC_HSIZE_WORD);
    // Zero wait states: every access completes in its first data cycle
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;
    assign HRDATA_O = rdata_ff;

    // Register readback, reserved bits read as zero
    reg [7:0] rd_mux;
    always @* begin
        case (a_idx)
            `APRC_IDX_PWR_PIN: rd_mux = pwr_pin_ff;
            `APRC_IDX_BIAS: rd_mux = bias_ff;
            `APRC_IDX_PORT: rd_mux = port_ff;
            `APRC_IDX_LANE: rd_mux = lane_ff;
            // Unmapped addresses read zero and answer OKAY
            default: rd_mux = 8'h00;
        endcase
    end

    // Address phase capture and read data launch
    always @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= {`APRC_IDX_W{1'b0}};
            rdata_ff <= 32'h00000000;
        end else begin
            wr_pend_ff <= a_valid && HWRITE_I;
            if (a_valid) begin
                wr_idx_ff <= a_idx;
            end
            if (a_valid && !HWRITE_I) begin
                rdata_ff <= {24'h000000, rd_mux};
            end
        end
    end

    // Data phase write into the addressed register
    always @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            pwr_pin_ff <= `APRC_RST_PWR_PIN;
            bias_ff <= `APRC_RST_BIAS;
            port_ff <= `APRC_RST_PORT;
            lane_ff <= `APRC_RST_LANE;
        end else if (wr_pend_ff) begin
            case (wr_idx_ff)
                `APRC_IDX_PWR_PIN: pwr_pin_ff <= HWDATA_I[7:0];
                `APRC_IDX_BIAS: bias_ff <= HWDATA_I[7:0] & `APRC_MASK_BIAS;
                `APRC_IDX_PORT: port_ff <= HWDATA_I[7:0];
                `APRC_IDX_LANE: lane_ff <= HWDATA_I[7:0] & `APRC_MASK_LANE;
                // Writes elsewhere are dropped
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin selection helper
    // ----------------------------------------------------------------
    // Level of the pin picked by a two-bit select, zero when disabled
    function pin_level;
        input [1:0] sel;
        begin
            case (sel)
                `APRC_PIN_G1: pin_level = GENERAL_PIN_ONE_I;
                `APRC_PIN_G2: pin_level = GENERAL_PIN_TWO_I;
                `APRC_PIN_IN: pin_level = INPUT_ONLY_PIN_I;
                default: pin_level = 1'b0;
            endcase
        end
    endfunction

    // Turns a lane split code into per-port lane counts
    reg [1:0] p_out_n;
    reg [1:0] s_out_n;
    reg [1:0] p_in_n;
    reg [1:0] s_in_n;
    reg [1:0] split_tmp;
    always @* begin
        split_tmp = lane_ff[`APRC_F_OUT_SPLIT];
        case (split_tmp)
            `APRC_SPLIT_EACH: begin
                p_out_n = 2'h1;
                s_out_n = 2'h1;
            end
            `APRC_SPLIT_PRI: begin
                p_out_n = 2'h2;
                s_out_n = 2'h0;
            end
            `APRC_SPLIT_SEC: begin
                p_out_n = 2'h0;
                s_out_n = 2'h2;
            end
            // Reserved code: no lanes rather than a guess
            default: begin
                p_out_n = 2'h0;
                s_out_n = 2'h0;
            end
        endcase
        split_tmp = lane_ff[`APRC_F_IN_SPLIT];
        case (split_tmp)
            `APRC_SPLIT_EACH: begin
                p_in_n = 2'h1;
                s_in_n = 2'h1;
            end
            `APRC_SPLIT_PRI: begin
                p_in_n = 2'h2;
                s_in_n = 2'h0;
            end
            `APRC_SPLIT_SEC: begin
                p_in_n = 2'h0;
                s_in_n = 2'h2;
            end
            default: begin
                p_in_n = 2'h0;
                s_in_n = 2'h0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Routing decode, registered so outputs come from flops
    // ----------------------------------------------------------------
    // decoded each cycle from stored fields
    always @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            MIC_LANE_ROUTE_O <= `APRC_PIN_NONE;
            MIC_LANE_FROM_DIN_O <= 1'b0;
            SHARED_DATA_PIN_O <= 1'b0;
            ADC_POWERDOWN_O <= 1'b0;
            DAC_POWERDOWN_O <= 1'b0;
            POWER_LIMITER_ON_PIN_O <= 1'b0;
            GENERAL_ANALOG_ON_PIN_O <= 1'b0;
            MICROPHONE_BIAS_EN_O <= 1'b0;
            PRIMARY_PORT_EN_O <= 1'b0;
            SECONDARY_PORT_EN_O <= 1'b0;
            PORT_CONFIG_GANG_O <= 1'b0;
            DAISY_PRIMARY_O <= 1'b0;
            DAISY_SECONDARY_O <= 1'b0;
            DAISY_INPUT_O <= 1'b0;
            DAISY_ON_INPUT_PATH_O <= 1'b0;
            PRIMARY_OUT_LANES_O <= 2'h0;
            SECONDARY_OUT_LANES_O <= 2'h0;
            PRIMARY_IN_LANES_O <= 2'h0;
            SECONDARY_IN_LANES_O <= 2'h0;
        end else begin
            if (pwr_pin_ff[`APRC_F_OVRD] && (MIC_LANE_SELECT_I == `APRC_MIC_DIN)) begin
                MIC_LANE_ROUTE_O <= `APRC_PIN_NONE;
                MIC_LANE_FROM_DIN_O <= 1'b1;
            end else begin
                MIC_LANE_ROUTE_O <= MIC_LANE_SELECT_I;
                MIC_LANE_FROM_DIN_O <= 1'b0;
            end
            SHARED_DATA_PIN_O <= pwr_pin_ff[`APRC_F_SHARED];
            // ADC pin pick; OR with register request
            ADC_POWERDOWN_O <= pin_level(pwr_pin_ff[`APRC_F_ADC_PD])
                               | ~ADC_REGISTER_POWER_CONTROL_I;
            // DAC pin pick; OR with register request
            DAC_POWERDOWN_O <= pin_level(pwr_pin_ff[`APRC_F_DAC_PD])
                               | ~DAC_REGISTER_POWER_CONTROL_I;
            POWER_LIMITER_ON_PIN_O <= pwr_pin_ff[`APRC_F_LIM];
            GENERAL_ANALOG_ON_PIN_O <= pwr_pin_ff[`APRC_F_ANA];
            MICROPHONE_BIAS_EN_O <= pin_level(bias_ff[`APRC_F_BIAS]);
            // primary enable; removed when secondary chains
            PRIMARY_PORT_EN_O <= ~port_ff[`APRC_F_PDIS]
                                 && (port_ff[`APRC_F_DAISY] != `APRC_DAISY_SEC);
            // secondary enable; removed when primary chains
            SECONDARY_PORT_EN_O <= ~port_ff[`APRC_F_SDIS]
                                   && (port_ff[`APRC_F_DAISY] != `APRC_DAISY_PRI);
            PORT_CONFIG_GANG_O <= port_ff[`APRC_F_GANG];
            DAISY_PRIMARY_O <= (port_ff[`APRC_F_DAISY] == `APRC_DAISY_PRI);
            DAISY_SECONDARY_O <= (port_ff[`APRC_F_DAISY] == `APRC_DAISY_SEC);
            case (port_ff[`APRC_F_DIN_SEL])
                `APRC_SRC_G1: DAISY_INPUT_O <= GENERAL_PIN_ONE_I;
                `APRC_SRC_G2: DAISY_INPUT_O <= GENERAL_PIN_TWO_I;
                `APRC_SRC_IN: DAISY_INPUT_O <= INPUT_ONLY_PIN_I;
                // Data-in gives a constant zero, shared or not; no pin level is sampled
                `APRC_SRC_DIN: DAISY_INPUT_O <= INPUT_ONLY_PIN_I & 1'b0;
                // Disabled and reserved codes give no input
                default: DAISY_INPUT_O <= 1'b0;
            endcase
            DAISY_ON_INPUT_PATH_O <= lane_ff[`APRC_F_DIR];
            PRIMARY_OUT_LANES_O <= p_out_n;
            SECONDARY_OUT_LANES_O <= s_out_n;
            PRIMARY_IN_LANES_O <= p_in_n;
            SECONDARY_IN_LANES_O <= s_in_n;
        end
    end

endmodule // aprc_pin_routing

// [tb/aprc_far_side.sv]
// Far-side model: host pin levels and power requests
`timescale 1ns/1ps
module aprc_far_side (
    input logic clk_i, // Core clock
    input logic [4:0] want_i, // {dac_on, adc_on, in_only, two, one}
    output logic pin_one_o, // General pin one
    output logic pin_two_o, // General pin two
    output logic pin_in_o, // Input-only pin
    output logic adc_on_o, // High keeps ADC powered
    output logic dac_on_o // High keeps DAC powered
);
    // Powered, pins low: clean levels from time zero
    logic [4:0] lvl_ff = 5'h18;
    // Host logic on the same clock moves just after an edge
    always @(posedge clk_i) begin
        lvl_ff <= want_i;
    end
    assign {dac_on_o, adc_on_o, pin_in_o, pin_two_o, pin_one_o} = lvl_ff;
endmodule // aprc_far_side

// [tb/aprc_pin_routing_chk.sv]
// Port assertions for the pin routing block
`timescale 1ns/1ps
module aprc_pin_routing_chk (
    input wire CORE_CLK_I, // Clock
    input wire RST_N_I, // Reset
    input wire HSEL_I, // Select
    input wire [31:0] HADDR_I, // Address
    input wire [1:0] HTRANS_I, // Transfer type
    input wire HWRITE_I, // Write flag
    input wire [2:0] HSIZE_I, // Size
    input wire [31:0] HWDATA_I, // Write data
    input wire HREADY_I, // Bus ready
    input wire [31:0] HRDATA_O, // Read data
    input wire HREADYOUT_O, // Slave ready
    input wire HRESP_O, // Response
    input wire ADC_REGISTER_POWER_CONTROL_I, // ADC keep-on
    input wire DAC_REGISTER_POWER_CONTROL_I, // DAC keep-on
    input wire [1:0] MIC_LANE_SELECT_I, // Mic lane code
    input wire [1:0] MIC_LANE_ROUTE_O, // Effective code
    input wire MIC_LANE_FROM_DIN_O, // Moved to data-in
    input wire ADC_POWERDOWN_O, // ADC down
    input wire DAC_POWERDOWN_O, // DAC down
    input wire PRIMARY_PORT_EN_O, // Primary on
    input wire SECONDARY_PORT_EN_O, // Secondary on
    input wire PORT_CONFIG_GANG_O, // Gang on
    input wire DAISY_PRIMARY_O, // Primary chained
    input wire DAISY_SECONDARY_O, // Secondary chained
    input wire [1:0] PRIMARY_OUT_LANES_O, // Primary out lanes
    input wire [1:0] SECONDARY_OUT_LANES_O // Secondary out lanes
);
    // ----------------------------------------------------------------
    // Helper logic
    // ----------------------------------------------------------------
    // Outputs sit low while the reset synchroniser drains, so wait it out
    logic [2:0] live_cnt_ff;
    wire live = (live_cnt_ff == 3'h5);
    always @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            live_cnt_ff <= 3'h0;
        end else if (!live) begin
            live_cnt_ff <= live_cnt_ff + 3'h1;
        end
    end
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // Word write to the port register: address phase, data phase, then the
    // register holds the word and the outputs take it one edge later
    sequence port_landed;
        live && HSEL_I && HREADY_I && HTRANS_I == 2'h2 && HWRITE_I && HSIZE_I == 3'h2
            && HADDR_I == 32'h60 ##2 1'b1;
    endsequence
    a_bus_always_okay: assert property (HREADYOUT_O && !HRESP_O && HRDATA_O[31:8] == 24'h0)
        else $error("slave stalled, erred or drove upper read bits");
    a_adc_reg_down: assert property (live && !ADC_REGISTER_POWER_CONTROL_I |=> ADC_POWERDOWN_O)
        else $error("ADC not down on register request");
    a_dac_reg_down: assert property (live && !DAC_REGISTER_POWER_CONTROL_I |=> DAC_POWERDOWN_O)
        else $error("DAC not down on register request");
    a_mic_override: assert property (live && MIC_LANE_FROM_DIN_O |->
        MIC_LANE_ROUTE_O == 2'h0 && $past(MIC_LANE_SELECT_I) == 2'h3)
        else $error("mic lane moved without input-only select");
    a_mic_follow: assert property (live && MIC_LANE_SELECT_I != 2'h3 |=>
        MIC_LANE_ROUTE_O == $past(MIC_LANE_SELECT_I) && !MIC_LANE_FROM_DIN_O)
        else $error("mic lane route did not follow select");
    a_pri_enable: assert property (port_landed |=>
        PRIMARY_PORT_EN_O == (!$past(HWDATA_I[7], 2) && $past(HWDATA_I[4:3], 2) != 2'h2))
        else $error("primary enable wrong after write");
    a_sec_enable: assert property (port_landed |=>
        SECONDARY_PORT_EN_O == (!$past(HWDATA_I[6], 2) && $past(HWDATA_I[4:3], 2) != 2'h1))
        else $error("secondary enable wrong after write");
    a_gang_copy: assert property (port_landed |=> PORT_CONFIG_GANG_O == $past(HWDATA_I[5], 2))
        else $error("gang output wrong after write");
    a_daisy_pri_only: assert property (live && DAISY_PRIMARY_O |->
        !SECONDARY_PORT_EN_O && !DAISY_SECONDARY_O)
        else $error("secondary port left while primary chained");
    a_daisy_sec_only: assert property (live && DAISY_SECONDARY_O |-> !PRIMARY_PORT_EN_O)
        else $error("primary port left while secondary chained");
    a_out_split: assert property ({PRIMARY_OUT_LANES_O, SECONDARY_OUT_LANES_O}
        inside {4'h0, 4'h2, 4'h5, 4'h8})
        else $error("output lane split not a legal pair");
endmodule // aprc_pin_routing_chk

bind aprc_pin_routing aprc_pin_routing_chk u_chk (.*);

// [tb/tb_top.sv]
// Self-checking bench for the pin routing block
`timescale 1ns/1ps
module tb_top;
    // ----------------------------------------------------------------
    // Nets named after the block's ports
    // ----------------------------------------------------------------
    logic CORE_CLK_I = 1'b0; // Clock
    logic RST_N_I = 1'b0; // Reset
    logic HSEL_I = 1'b0; // Select
    logic [31:0] HADDR_I = 32'h0; // Address
    logic [1:0] HTRANS_I = 2'h0; // Idle
    logic HWRITE_I = 1'b0; // Write flag
    logic [2:0] HSIZE_I = 3'h2; // Whole words only
    logic [31:0] HWDATA_I = 32'h0; // Write data
    logic [1:0] MIC_LANE_SELECT_I = 2'h0; // Mic lane code
    logic [4:0] want = 5'h18; // Levels asked of far side
    int failures = 0;
    int check_count = 0;
    wire HREADYOUT_O, HRESP_O, GENERAL_PIN_ONE_I, GENERAL_PIN_TWO_I, INPUT_ONLY_PIN_I;
    wire ADC_REGISTER_POWER_CONTROL_I, DAC_REGISTER_POWER_CONTROL_I, MIC_LANE_FROM_DIN_O;
    wire SHARED_DATA_PIN_O, ADC_POWERDOWN_O, DAC_POWERDOWN_O, POWER_LIMITER_ON_PIN_O;
    wire GENERAL_ANALOG_ON_PIN_O, MICROPHONE_BIAS_EN_O, PRIMARY_PORT_EN_O, SECONDARY_PORT_EN_O;
    wire PORT_CONFIG_GANG_O, DAISY_PRIMARY_O, DAISY_SECONDARY_O, DAISY_INPUT_O;
    wire DAISY_ON_INPUT_PATH_O;
    wire [1:0] MIC_LANE_ROUTE_O, PRIMARY_OUT_LANES_O, SECONDARY_OUT_LANES_O;
    wire [1:0] PRIMARY_IN_LANES_O, SECONDARY_IN_LANES_O;
    wire [31:0] HRDATA_O;
    wire HREADY_I = HREADYOUT_O; // Single slave: its ready is the bus ready

    aprc_pin_routing dut (.*);
    aprc_far_side u_far (.clk_i(CORE_CLK_I), .want_i(want), .pin_one_o(GENERAL_PIN_ONE_I),
        .pin_two_o(GENERAL_PIN_TWO_I), .pin_in_o(INPUT_ONLY_PIN_I),
        .adc_on_o(ADC_REGISTER_POWER_CONTROL_I), .dac_on_o(DAC_REGISTER_POWER_CONTROL_I));

    always #4 CORE_CLK_I = ~CORE_CLK_I;

    task automatic give_verdict;
        $display("Checks %0d, failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Bounded wait for ready; a stuck slave ends the run
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge CORE_CLK_I);
            n++;
        end while (HREADYOUT_O !== 1'b1 && n < 64);
        if (HREADYOUT_O !== 1'b1) begin
            failures++;
            give_verdict();
        end
    endtask

    // One single word transfer; hsel stays up so calls may run back to back
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r);
        HSEL_I <= 1'b1;
        HTRANS_I <= 2'h2;
        HADDR_I <= a;
        HWRITE_I <= wr;
        wait_ready();
        HTRANS_I <= 2'h0;
        HWDATA_I <= d;
        wait_ready();
        r = HRDATA_O;
    endtask

    // Level of the pin a 1..3 code selects; anything else reads low
    function automatic logic pick(input logic [2:0] c);
        pick = (c != 3'h0 && c < 3'h4) ? want[c - 3'h1] : 1'b0;
    endfunction

    // Lane counts {primary, secondary}; reserved code leaves both at zero
    function automatic logic [3:0] split(input logic [1:0] c);
        case (c)
            2'h0: split = 4'h5;
            2'h1: split = 4'h8;
            2'h2: split = 4'h2;
            default: split = 4'h0;
        endcase
    endfunction

    task automatic reset_values;
        logic [31:0] rd;
        bus(1'b0, 32'h50, 32'h0, rd);
        chk(rd, 32'h0);
        bus(1'b0, 32'h54, 32'h0, rd);
        chk(rd, 32'h0);
        bus(1'b0, 32'h60, 32'h0, rd);
        chk(rd, 32'h40);
        bus(1'b0, 32'h64, 32'h0, rd);
        chk(rd, 32'h0);
        bus(1'b0, 32'h70, 32'h0, rd);
        chk(rd, 32'h0);
        chk({PRIMARY_PORT_EN_O, SECONDARY_PORT_EN_O}, 2'h2);
    endtask

    initial begin
        logic [31:0] rd;
        logic [7:0] cfg;
        logic [7:0] aux;
        logic [1:0] mic;
        logic [2:0] e;
        void'($urandom(32'hF8B0));
        repeat (20) @(posedge CORE_CLK_I);
        RST_N_I <= 1'b1;
        repeat (5) @(posedge CORE_CLK_I);
        reset_values();
        // Power-down, pin functions, bias and mic lane under random pins
        for (int i = 0; i < 32; i++) begin
            cfg = 8'($urandom);
            // reserved bias bits written as zero
            aux = 8'($urandom) & 8'hC0;
            mic = (i < 4) ? 2'h3 : 2'($urandom);
            cfg[5:4] = i[1:0];
            // Corner: override both ways while the mic sits on the input-only pin
            cfg[7] = (i < 4) ? i[0] : cfg[7];
            bus(1'b1, 32'h50, {24'h0, cfg}, rd);
            bus(1'b1, 32'h54, {24'h0, aux}, rd);
            bus(1'b0, 32'h54, 32'h0, rd);
            chk(rd, {24'h0, aux & 8'hC0});
            want <= 5'($urandom);
            MIC_LANE_SELECT_I <= mic;
            repeat (3) @(posedge CORE_CLK_I);
            e = (cfg[7] && mic == 2'h3) ? 3'h4 : {1'b0, mic};
            chk(ADC_POWERDOWN_O, pick({1'b0, cfg[5:4]}) | !want[3]);
            chk(DAC_POWERDOWN_O, pick({1'b0, cfg[3:2]}) | !want[4]);
            chk({SHARED_DATA_PIN_O, POWER_LIMITER_ON_PIN_O}, cfg[6:5] & 2'h2 | cfg[1]);
            chk(GENERAL_ANALOG_ON_PIN_O, cfg[0]);
            chk(MICROPHONE_BIAS_EN_O, pick({1'b0, aux[7:6]}));
            chk({MIC_LANE_FROM_DIN_O, MIC_LANE_ROUTE_O}, e);
        end
        // Port enables, gang, daisy modes and every legal daisy input code
        for (int i = 0; i < 24; i++) begin
            cfg = 8'($urandom);
            // reserved daisy input codes replaced by data-in
            cfg[2:0] = (i[2:0] > 3'h3) ? 3'h5 : i[2:0];
            cfg[4:3] = 2'(i % 3);
            bus(1'b1, 32'h60, {24'h0, cfg}, rd);
            bus(1'b0, 32'h60, 32'h0, rd);
            chk(rd, {24'h0, cfg});
            want <= 5'($urandom);
            repeat (3) @(posedge CORE_CLK_I);
            chk(PRIMARY_PORT_EN_O, !cfg[7] && cfg[4:3] != 2'h2);
            chk(SECONDARY_PORT_EN_O, !cfg[6] && cfg[4:3] != 2'h1);
            chk(PORT_CONFIG_GANG_O, cfg[5]);
            chk({DAISY_PRIMARY_O, DAISY_SECONDARY_O}, {cfg[3], cfg[4]});
            chk(DAISY_INPUT_O, pick(cfg[2:0]));
        end
        // Every legal lane split pair and both daisy directions
        for (int i = 0; i < 16; i++) begin
            cfg = 8'($urandom);
            // no reserved split code, reserved bits zero
            cfg[7:6] = 2'(i % 3);
            cfg[5:4] = 2'((i / 3) % 3);
            cfg[2:0] = 3'h0;
            bus(1'b1, 32'h64, {24'h0, cfg}, rd);
            bus(1'b0, 32'h64, 32'h0, rd);
            chk(rd, {24'h0, cfg & 8'hF8});
            repeat (3) @(posedge CORE_CLK_I);
            chk({PRIMARY_OUT_LANES_O, SECONDARY_OUT_LANES_O}, split(cfg[7:6]));
            chk({PRIMARY_IN_LANES_O, SECONDARY_IN_LANES_O}, split(cfg[5:4]));
            chk(DAISY_ON_INPUT_PATH_O, cfg[3]);
        end
        // Reset in mid-run clears outputs and restores register values
        RST_N_I <= 1'b0;
        repeat (3) @(posedge CORE_CLK_I);
        chk({PRIMARY_PORT_EN_O, DAISY_ON_INPUT_PATH_O}, 2'h0);
        RST_N_I <= 1'b1;
        repeat (5) @(posedge CORE_CLK_I);
        reset_values();
        give_verdict();
    end
endmodule // tb_top
